// ### verilog/tpw_consts.vh
// constants of the three channel pulse width timer
`ifndef TPW_CONSTS_VH
`define TPW_CONSTS_VH

// register indices; byte address is four times the index
`define TPW_IDX_CTRL1 16'hfef0
`define TPW_IDX_DUTY1 16'hfef1
`define TPW_IDX_CNT1 16'hfef2
`define TPW_IDX_CTRL2 16'hfef4
`define TPW_IDX_DUTY2 16'hfef5
`define TPW_IDX_CNT2 16'hfef6
`define TPW_IDX_CTRL3 16'hfef8
`define TPW_IDX_DUTY3 16'hfef9
`define TPW_IDX_CNT3 16'hfefa
`define TPW_ID_NONE 4'hf

// register kinds inside a channel
`define TPW_KIND_CTRL 2'd0
`define TPW_KIND_DUTY 2'd1
`define TPW_KIND_CNT 2'd2

// reset values
`define TPW_CTRL_RST 8'h38
`define TPW_DUTY_RST 8'hff
`define TPW_CNT_RST 8'h00

// control field positions
`define TPW_CTRL_OE 7
`define TPW_CTRL_OS 6
`define TPW_CTRL_RSV 3'b111

// counter limits and duty codes
`define TPW_CNT_TOP 8'hf9
`define TPW_CNT_ONE 8'h01
`define TPW_DUTY_ZERO 8'h00

// prescaler width and divisors for codes 0 to 7
`define TPW_PRE_W 12
`define TPW_DIV0 13'd2
`define TPW_DIV1 13'd8
`define TPW_DIV2 13'd32
`define TPW_DIV3 13'd128
`define TPW_DIV4 13'd256
`define TPW_DIV5 13'd1024
`define TPW_DIV6 13'd2048
`define TPW_DIV7 13'd4096

// bus responses
`define TPW_RESP_OKAY 2'b00
`define TPW_RESP_SLVERR 2'b10

`endif

// ### verilog/tpw_presc.v
// free-running prescaler making the eight tick enables
`include "tpw_consts.vh"

module tpw_presc (
    input wire aclk,
    input wire aresetn,
    input wire standby,
    output wire [7:0] tick
);
    reg [`TPW_PRE_W-1:0] cnt_q;

    // tick when the low bits of the count are all ones
    function is_tick;
        input [`TPW_PRE_W-1:0] c;
        input [`TPW_PRE_W-1:0] mask;
        begin
            is_tick = ((c & mask) == mask);
        end
    endfunction

    // low-bit mask of a power-of-two divisor
    function [`TPW_PRE_W-1:0] div_mask;
        input [`TPW_PRE_W:0] div;
        reg [`TPW_PRE_W:0] m;
        begin
            m = div - 1'b1;
            div_mask = m[`TPW_PRE_W-1:0];
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn || standby) begin
            cnt_q <= {`TPW_PRE_W{1'b0}};
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // one-cycle enables, one per divider code
    assign tick[0] = is_tick(cnt_q, div_mask(`TPW_DIV0));
    assign tick[1] = is_tick(cnt_q, div_mask(`TPW_DIV1));
    assign tick[2] = is_tick(cnt_q, div_mask(`TPW_DIV2));
    assign tick[3] = is_tick(cnt_q, div_mask(`TPW_DIV3));
    assign tick[4] = is_tick(cnt_q, div_mask(`TPW_DIV4));
    assign tick[5] = is_tick(cnt_q, div_mask(`TPW_DIV5));
    assign tick[6] = is_tick(cnt_q, div_mask(`TPW_DIV6));
    assign tick[7] = is_tick(cnt_q, div_mask(`TPW_DIV7));
endmodule // tpw_presc

// ### verilog/tpw_chan.v
// one pulse width channel: counter, duty buffer, control, pin
`include "tpw_consts.vh"

module tpw_chan (
    input wire aclk,
    input wire aresetn,
    input wire standby,
    input wire [7:0] tick,
    input wire wr_ctrl,
    input wire wr_duty,
    input wire wr_cnt,
    input wire [7:0] wdata,
    output wire [7:0] ctrl_rd,
    output wire [7:0] duty_rd,
    output wire [7:0] cnt_rd,
    output reg pulse_q,
    output reg pulse_oe_q
);
    reg [7:0] cnt_q;
    reg [4:0] ctrl_q;
    reg [7:0] duty_act_q;
    reg [7:0] duty_buf_q;
    reg state_q;
    localparam [7:0] CTRL_RST = `TPW_CTRL_RST;
    wire oe = ctrl_q[4];
    wire step = oe & tick[ctrl_q[2:0]];
    wire wrap = step & (cnt_q == `TPW_CNT_TOP);
    wire [7:0] cnt_nx = wrap ? `TPW_CNT_RST : cnt_q + `TPW_CNT_ONE;

    assign ctrl_rd = {ctrl_q[4:3], `TPW_CTRL_RSV, ctrl_q[2:0]};
    assign duty_rd = duty_act_q;
    assign cnt_rd = cnt_q;

    always @(posedge aclk) begin
        if (!aresetn || standby) begin
            cnt_q <= `TPW_CNT_RST;
            ctrl_q <= {CTRL_RST[7:6], CTRL_RST[2:0]};
            duty_act_q <= `TPW_DUTY_RST;
            duty_buf_q <= `TPW_DUTY_RST;
            state_q <= 1'b0;
            pulse_q <= 1'b0;
            pulse_oe_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {wdata[`TPW_CTRL_OE:`TPW_CTRL_OS], wdata[2:0]};
            end
            if (wr_ctrl && !wdata[`TPW_CTRL_OE]) begin
                cnt_q <= `TPW_CNT_RST;
            end else if (wr_cnt) begin
                cnt_q <= wdata;
            end else if (!oe) begin
                cnt_q <= `TPW_CNT_RST;
            end else if (step) begin
                cnt_q <= cnt_nx;
            end
            if (wr_duty) begin
                duty_buf_q <= wdata;
                if (!oe || wrap) begin
                    duty_act_q <= wdata;
                end
            end else if (wrap) begin
                duty_act_q <= duty_buf_q;
            end
            if (!oe) begin
                state_q <= 1'b0;
            end else if (step && cnt_q == duty_act_q) begin
                // low once the matching count ends: duty n is n ticks
                state_q <= 1'b0;
            end else if (step && cnt_q == `TPW_CNT_RST) begin
                state_q <= (duty_act_q != `TPW_DUTY_ZERO);
            end
            pulse_q <= oe & (state_q ^ ctrl_q[3]);
            pulse_oe_q <= oe;
        end
    end
endmodule // tpw_chan

// ### verilog/tpw_top.v
// three channel pulse width timer with its register slave
//
// Summary of operation
// - three channels, own registers each, one shared prescaler
// - counter steps 0x00 to 0xf9, wraps
// - counter zero on reset, standby, disable
// - duty 0x00 none, 0x7d half, 0xfa full
// - count equals duty drives state low
// - count 0 to 1 sets state high
// - enabled duty write waits for wrap
// - disabled duty write takes effect immediately
// - duty read returns active value
// - duty copies reset to 0xff
// - control resets to 0x38
// - bit 7 enables output and counting
// - bit 6 inverts the pin level
// - bits 5 to 3 read as one
// - divider codes give 2 to 4096
// - period is 250 ticks
// - duty 0xfa to 0xff stays high
// - disabled channel leaves pin undriven
//
// Register access over AXI4-Lite was decided locally.
`include "tpw_consts.vh"

module tpw_top #(
    parameter ADDR_W = 18
) (
    input wire aclk,
    input wire aresetn,
    input wire standby,
    input wire awvalid,
    output reg awready,
    input wire [ADDR_W-1:0] awaddr,
    input wire [2:0] awprot,
    input wire wvalid,
    output reg wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    input wire arvalid,
    output reg arready,
    input wire [ADDR_W-1:0] araddr,
    input wire [2:0] arprot,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output wire pulse_out_1,
    output wire pulse_oe_1,
    output wire pulse_out_2,
    output wire pulse_oe_2,
    output wire pulse_out_3,
    output wire pulse_oe_3
);
    // register id: channel in bits 3:2, kind in bits 1:0
    function [3:0] reg_id;
        input [15:0] idx;
        begin
            case (idx)
                `TPW_IDX_CTRL1: reg_id = {2'd0, `TPW_KIND_CTRL};
                `TPW_IDX_DUTY1: reg_id = {2'd0, `TPW_KIND_DUTY};
                `TPW_IDX_CNT1: reg_id = {2'd0, `TPW_KIND_CNT};
                `TPW_IDX_CTRL2: reg_id = {2'd1, `TPW_KIND_CTRL};
                `TPW_IDX_DUTY2: reg_id = {2'd1, `TPW_KIND_DUTY};
                `TPW_IDX_CNT2: reg_id = {2'd1, `TPW_KIND_CNT};
                `TPW_IDX_CTRL3: reg_id = {2'd2, `TPW_KIND_CTRL};
                `TPW_IDX_DUTY3: reg_id = {2'd2, `TPW_KIND_DUTY};
                `TPW_IDX_CNT3: reg_id = {2'd2, `TPW_KIND_CNT};
                default: reg_id = `TPW_ID_NONE;
            endcase
        end
    endfunction

    // strobe for one channel and one kind of register
    function wr_hit;
        input [3:0] id;
        input [1:0] chan;
        input [1:0] kind;
        begin
            wr_hit = (id == {chan, kind});
        end
    endfunction

    // write address and data holding
    reg aw_hold_q;
    reg w_hold_q;
    reg [15:0] waddr_q;
    reg [7:0] wdata_q;
    reg wlane_q;
    wire aw_fire = awvalid & awready;
    wire w_fire = wvalid & wready;
    wire do_wr = aw_hold_q & w_hold_q & ~bvalid;
    wire aw_hold_d = aw_fire | (aw_hold_q & ~do_wr);
    wire w_hold_d = w_fire | (w_hold_q & ~do_wr);
    wire [3:0] wr_id = reg_id(waddr_q);
    wire wr_ok = do_wr & wlane_q;

    // read side
    wire ar_fire = arvalid & arready;
    wire rvalid_d = ar_fire | (rvalid & ~rready);
    wire [3:0] rd_id = reg_id(araddr[ADDR_W-1:2]);

    // channel register strobes
    wire [2:0] wr_ctrl;
    wire [2:0] wr_duty;
    wire [2:0] wr_cnt;

    // channel read values, eight bits per channel
    wire [23:0] ctrl_rd;
    wire [23:0] duty_rd;
    wire [23:0] cnt_rd;
    wire [7:0] tick;
    reg [7:0] rd_val;

    assign wr_ctrl[0] = wr_ok & wr_hit(wr_id, 2'd0, `TPW_KIND_CTRL);
    assign wr_ctrl[1] = wr_ok & wr_hit(wr_id, 2'd1, `TPW_KIND_CTRL);
    assign wr_ctrl[2] = wr_ok & wr_hit(wr_id, 2'd2, `TPW_KIND_CTRL);
    assign wr_duty[0] = wr_ok & wr_hit(wr_id, 2'd0, `TPW_KIND_DUTY);
    assign wr_duty[1] = wr_ok & wr_hit(wr_id, 2'd1, `TPW_KIND_DUTY);
    assign wr_duty[2] = wr_ok & wr_hit(wr_id, 2'd2, `TPW_KIND_DUTY);
    // counter writes are a test path only
    assign wr_cnt[0] = wr_ok & wr_hit(wr_id, 2'd0, `TPW_KIND_CNT);
    assign wr_cnt[1] = wr_ok & wr_hit(wr_id, 2'd1, `TPW_KIND_CNT);
    assign wr_cnt[2] = wr_ok & wr_hit(wr_id, 2'd2, `TPW_KIND_CNT);

    // read mux over the mapped registers
    always @* begin
        rd_val = 8'h00;
        case (rd_id[1:0])
            `TPW_KIND_CTRL: rd_val = ctrl_rd[{rd_id[3:2], 3'b000} +: 8];
            `TPW_KIND_DUTY: rd_val = duty_rd[{rd_id[3:2], 3'b000} +: 8];
            `TPW_KIND_CNT: rd_val = cnt_rd[{rd_id[3:2], 3'b000} +: 8];
            default: rd_val = 8'h00;
        endcase
    end

    // write channel of the register slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            waddr_q <= 16'h0000;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `TPW_RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            if (aw_fire) begin
                waddr_q <= awaddr[ADDR_W-1:2];
            end
            if (w_fire) begin
                wdata_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end
            awready <= ~aw_hold_d;
            wready <= ~w_hold_d;
            if (do_wr) begin
                bvalid <= 1'b1;
                if (wr_id == `TPW_ID_NONE) begin
                    bresp <= `TPW_RESP_SLVERR;
                end else begin
                    bresp <= `TPW_RESP_OKAY;
                end
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel of the register slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `TPW_RESP_OKAY;
        end else begin
            rvalid <= rvalid_d;
            arready <= ~rvalid_d;
            if (ar_fire) begin
                rdata <= {24'h000000, rd_val};
                if (rd_id == `TPW_ID_NONE) begin
                    rresp <= `TPW_RESP_SLVERR;
                end else begin
                    rresp <= `TPW_RESP_OKAY;
                end
            end
        end
    end

    // shared prescaler keeps all channels on aclk
    tpw_presc u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .standby(standby),
        .tick(tick)
    );

    // channel 1; period of 250 ticks per channel
    tpw_chan u_chan1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .standby(standby),
        .tick(tick),
        .wr_ctrl(wr_ctrl[0]),
        .wr_duty(wr_duty[0]),
        .wr_cnt(wr_cnt[0]),
        .wdata(wdata_q),
        .ctrl_rd(ctrl_rd[7:0]),
        .duty_rd(duty_rd[7:0]),
        .cnt_rd(cnt_rd[7:0]),
        .pulse_q(pulse_out_1),
        .pulse_oe_q(pulse_oe_1)
    );

    // channel 2
    tpw_chan u_chan2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .standby(standby),
        .tick(tick),
        .wr_ctrl(wr_ctrl[1]),
        .wr_duty(wr_duty[1]),
        .wr_cnt(wr_cnt[1]),
        .wdata(wdata_q),
        .ctrl_rd(ctrl_rd[15:8]),
        .duty_rd(duty_rd[15:8]),
        .cnt_rd(cnt_rd[15:8]),
        .pulse_q(pulse_out_2),
        .pulse_oe_q(pulse_oe_2)
    );

    // channel 3; duty codes 0xfa and up never match the count
    tpw_chan u_chan3 (
        .aclk(aclk),
        .aresetn(aresetn),
        .standby(standby),
        .tick(tick),
        .wr_ctrl(wr_ctrl[2]),
        .wr_duty(wr_duty[2]),
        .wr_cnt(wr_cnt[2]),
        .wdata(wdata_q),
        .ctrl_rd(ctrl_rd[23:16]),
        .duty_rd(duty_rd[23:16]),
        .cnt_rd(cnt_rd[23:16]),
        .pulse_q(pulse_out_3),
        .pulse_oe_q(pulse_oe_3)
    );
endmodule // tpw_top

// ### dv/tpw_top_sva.sv
// assertion checker for the pulse width timer ports
module tpw_top_sva (
    input wire aclk,
    input wire aresetn,
    input wire standby,
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire arvalid,
    input wire arready,
    input wire bvalid,
    input wire bready,
    input wire rvalid,
    input wire rready,
    input wire [31:0] rdata,
    input wire pulse_out_1,
    input wire pulse_oe_1,
    input wire pulse_oe_2,
    input wire pulse_oe_3
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_OFF_QUIET: assert property (!pulse_oe_1 |-> !pulse_out_1)
        else $error("pin high while channel disabled");
    AST_STANDBY_OFF: assert property (standby [*3] |->
        !(pulse_oe_1 || pulse_oe_2 || pulse_oe_3))
        else $error("channel enabled during standby");
    AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    AST_R_HIGH_ZERO: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_B_DROP: assert property (bvalid && bready |=> !bvalid)
        else $error("write response not released");
    AST_W_DONE: assert property (awvalid && awready && wvalid && wready
        |=> !awready ##1 bvalid)
        else $error("write response late");
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> !bvalid && !rvalid)
        else $error("response pending after reset");
    COV_RISE: cover property (pulse_oe_1 && $rose(pulse_out_1));
    COV_STANDBY: cover property (standby [*3]);
    COV_READ: cover property (rvalid && rready);
endmodule // tpw_top_sva

// ### dv/tpw_top_tb.sv
// self-checking testbench of the pulse width timer
`include "tpw_consts.vh"
module tpw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, standby = 0;
    logic awvalid = 0, wvalid = 0, arvalid = 0;
    logic [17:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire pulse_out_1, pulse_oe_1, pulse_out_2, pulse_oe_2;
    wire pulse_out_3, pulse_oe_3;
    int cyc = 0, failures = 0, tests_run = 0;
    tpw_top tpw_top_i (.aclk(aclk), .aresetn(aresetn), .standby(standby),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'h1), .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(1'b1), .rdata(rdata),
        .rresp(rresp), .pulse_out_1(pulse_out_1), .pulse_oe_1(pulse_oe_1),
        .pulse_out_2(pulse_out_2), .pulse_oe_2(pulse_oe_2),
        .pulse_out_3(pulse_out_3), .pulse_oe_3(pulse_oe_3));
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures = failures + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (!bvalid);
        chk({30'h0, bresp}, 32'h0);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
        input logic [1:0] er);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (!rvalid);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    // counts high cycles of channel one over one whole period at code 0
    task automatic hc(input logic [7:0] ctl, input logic [7:0] duty,
        input logic [31:0] exp);
        logic [31:0] n;
        n = 0;
        wr(`TPW_IDX_CTRL1, ctl & 8'h7f);
        wr(`TPW_IDX_DUTY1, duty);
        wr(`TPW_IDX_CTRL1, ctl);
        repeat (20) @(posedge aclk);
        repeat (500) begin
            @(posedge aclk);
            n = n + {31'h0, pulse_out_1};
        end
        chk(n, exp);
    endtask
    task automatic t_reset_values();
        for (int c = 0; c < 3; c++) begin
            rd(16'(`TPW_IDX_CTRL1 + 4 * c), 32'h38, 2'b00);
            rd(16'(`TPW_IDX_DUTY1 + 4 * c), 32'hff, 2'b00);
            rd(16'(`TPW_IDX_CNT1 + 4 * c), 32'h00, 2'b00);
        end
    endtask
    task automatic t_reserved_unmapped();
        wr(`TPW_IDX_CTRL2, 8'h07);
        rd(`TPW_IDX_CTRL2, 32'h3f, 2'b00);
        rd(16'hfef3, 32'h0, 2'b10);
        wr(`TPW_IDX_CNT2, 8'h55);
        rd(`TPW_IDX_CNT2, 32'h00, 2'b00);
        wr(`TPW_IDX_DUTY2, 8'h7d);
        rd(`TPW_IDX_DUTY2, 32'h7d, 2'b00);
    endtask
    task automatic t_duty_shapes();
        hc(8'h80, 8'h7d, 250);
        chk({31'h0, pulse_oe_1}, 1);
        chk({31'h0, pulse_oe_2}, 0);
        chk({29'h0, pulse_out_2, pulse_out_3, pulse_oe_3}, 0);
        hc(8'h80, 8'h00, 0);
        hc(8'h80, 8'hfa, 500);
        hc(8'h80, 8'hff, 500);
        hc(8'hc0, 8'h7d, 250);
        hc(8'hc0, 8'h00, 500);
    endtask
    task automatic t_dividers_buffer();
        logic [31:0] dv [3] = '{2, 8, 32};
        logic [63:0] t0;
        for (int c = 0; c < 3; c++) begin
            wr(`TPW_IDX_CTRL1, {5'b00000, 3'(c)});
            wr(`TPW_IDX_DUTY1, 8'h7d);
            wr(`TPW_IDX_CTRL1, {5'b10000, 3'(c)});
            @(posedge pulse_out_1);
            t0 = $time;
            @(posedge pulse_out_1);
            chk(32'(($time - t0) / 10), 250 * dv[c]);
        end
        wr(`TPW_IDX_DUTY1, 8'h20);
        rd(`TPW_IDX_DUTY1, 32'h7d, 2'b00);
        rd(`TPW_IDX_CNT3, 32'h00, 2'b00);
        @(posedge pulse_out_1);
        rd(`TPW_IDX_DUTY1, 32'h20, 2'b00);
        wr(`TPW_IDX_CTRL1, 8'h00);
        rd(`TPW_IDX_CNT1, 32'h00, 2'b00);
        chk({31'h0, pulse_oe_1}, 0);
    endtask
    task automatic t_standby();
        wr(`TPW_IDX_CTRL1, 8'h01);
        wr(`TPW_IDX_CTRL1, 8'h81);
        wr(`TPW_IDX_DUTY3, 8'h10);
        standby <= 1'b1;
        repeat (3) @(posedge aclk);
        standby <= 1'b0;
        @(posedge aclk);
        rd(`TPW_IDX_CTRL1, 32'h38, 2'b00);
        rd(`TPW_IDX_DUTY3, 32'hff, 2'b00);
        rd(`TPW_IDX_CNT1, 32'h00, 2'b00);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_values();
        t_reserved_unmapped();
        t_duty_shapes();
        t_dividers_buffer();
        t_standby();
        complete_run();
    end
endmodule // tpw_top_tb

bind tpw_top tpw_top_sva tpw_top_sva_i (.aclk(aclk), .aresetn(aresetn),
    .standby(standby), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .arvalid(arvalid), .arready(arready),
    .bvalid(bvalid), .bready(bready), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .pulse_out_1(pulse_out_1), .pulse_oe_1(pulse_oe_1),
    .pulse_oe_2(pulse_oe_2), .pulse_oe_3(pulse_oe_3));
